// [verilog/cfp_fifo.sv]
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps

// Contract
// - Store data_in on write edge when enable_a high, enable_b low, input ready high.
// - Advance output on read edge when read and both output enables low, ready high.
// - First word into empty memory moves to output register regardless of enables.
// - Output ready rises with first word on third read edge after the write.
// - While output ready is low, data_out keeps the last word read.
// - Output ready low when empty, read-clock synchronous; reads then ignored.
// - Input ready low when full, write-clock synchronous; writes then ignored.
// - Input ready low in reset, rises on second write edge after release.
// - Reset sets input ready, output ready, half-full low and almost flag high.
// - Half-full high when stored count is 32 or more.
// - Almost flag high when count at most empty offset or at least 64 minus full.
// - Strobe low at write edge before first write captures low five data bits.
// - Either output enable high drops data_out_en and blocks reads; data_out stays driven.
// - Input and output data ports are 18 bits wide.
// - Works with write and read clocks unrelated or identical.
// - First strobe edge loads both offsets; consecutive strobe edges after it reload full offset.
// - Memory writes blocked while offsets are being programmed.
module cfp_fifo
    import cfp_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int AW = ADDR_W
) (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Write side pins
    input wire logic write_clock,
    input wire logic write_enable_a,
    input wire logic write_enable_b,
    input wire logic offset_program_strobe,
    input wire logic [WIDTH-1:0] data_in,
    output logic input_ready_flag,
    // Read side pins
    input wire logic read_clock,
    input wire logic read_enable_n,
    input wire logic output_enable_a_n,
    input wire logic output_enable_b_n,
    output logic [WIDTH-1:0] data_out,
    output logic data_out_en,
    output logic output_ready_flag,
    // Status pins
    output logic half_full_flag,
    output logic almost_flag,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    localparam int PW = AW + 1;
    localparam int SW = WIDTH + 8;

    initial begin
        if (WIDTH != DATA_W || AW != ADDR_W) begin
            $error("cfp_fifo: geometry must match the flag constants");
        end
    end

    // ==========================================
    // Pin synchronisers
    logic [SW-1:0] pin_s1_q;
    logic [SW-1:0] pin_s2_q;
    logic wclk_s3_q;
    logic rclk_s3_q;

    always_ff @(posedge clk) begin
        pin_s1_q <= {write_clock, read_clock, write_enable_a, write_enable_b, read_enable_n,
                     output_enable_a_n, output_enable_b_n, offset_program_strobe, data_in};
        pin_s2_q <= pin_s1_q;
        wclk_s3_q <= pin_s2_q[SW-1];
        rclk_s3_q <= pin_s2_q[SW-2];
    end

    logic wclk_s;
    logic rclk_s;
    logic wea_s;
    logic web_s;
    logic ren_n_s;
    logic oea_n_s;
    logic oeb_n_s;
    logic pstb_s;
    logic [WIDTH-1:0] din_s;
    logic w_edge;
    logic r_edge;

    assign {wclk_s, rclk_s, wea_s, web_s, ren_n_s, oea_n_s, oeb_n_s, pstb_s, din_s} = pin_s2_q;
    assign w_edge = wclk_s & ~wclk_s3_q;
    assign r_edge = rclk_s & ~rclk_s3_q;

    // ==========================================
    // Write side
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];
    logic [PW-1:0] wptr_q;
    logic [PW-1:0] rptr_q;
    logic [PW-1:0] rptr_w1_q;
    logic [PW-1:0] rptr_w2_q;
    logic wrdy_q;
    logic ir_q;
    cfp_ofs_e ofs_q;
    logic [OFS_W-1:0] ofs_empty_q;
    logic [OFS_W-1:0] ofs_full_q;
    logic prog_now;
    logic wr_fire;
    logic [PW-1:0] wptr_n;

    assign prog_now = (ofs_q != CFP_OFS_SHUT) && !pstb_s && ir_q;
    assign wr_fire = w_edge && wea_s && !web_s && ir_q && !prog_now;
    assign wptr_n = wptr_q + PW'(wr_fire);

    always_ff @(posedge clk) begin
        if (wr_fire) begin
            mem[wptr_q[AW-1:0]] <= din_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wptr_q <= '0;
        end else if (wr_fire) begin
            wptr_q <= wptr_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rptr_w1_q <= '0;
            rptr_w2_q <= '0;
        end else if (w_edge) begin
            rptr_w1_q <= rptr_q;
            rptr_w2_q <= rptr_w1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrdy_q <= 1'b0;
            ir_q <= 1'b0;
        end else if (w_edge) begin
            wrdy_q <= 1'b1;
            ir_q <= wrdy_q && ((wptr_n - rptr_w2_q) != DEPTH_WORDS);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ofs_q <= CFP_OFS_OPEN;
            ofs_empty_q <= DEFAULT_OFFSET;
            ofs_full_q <= DEFAULT_OFFSET;
        end else if (reg_wr && reg_addr == REG_OFFSET) begin
            ofs_empty_q <= reg_wdata[OF_EMPTY_LSB +: OFS_W];
            ofs_full_q <= reg_wdata[OF_FULL_LSB +: OFS_W];
        end else if (w_edge) begin
            case (ofs_q)
                CFP_OFS_OPEN: begin
                    if (wr_fire) begin
                        ofs_q <= CFP_OFS_SHUT;
                    end else if (prog_now) begin
                        ofs_empty_q <= din_s[OFS_W-1:0];
                        ofs_full_q <= din_s[OFS_W-1:0];
                        ofs_q <= CFP_OFS_LOAD;
                    end
                end
                CFP_OFS_LOAD: begin
                    if (prog_now) begin
                        ofs_full_q <= din_s[OFS_W-1:0];
                    end else begin
                        ofs_q <= wr_fire ? CFP_OFS_SHUT : CFP_OFS_OPEN;
                    end
                end
                CFP_OFS_SHUT: begin
                    ofs_q <= CFP_OFS_SHUT;
                end
                default: begin
                    ofs_q <= CFP_OFS_SHUT;
                end
            endcase
        end
    end

    // ==========================================
    // Read side
    logic [PW-1:0] wptr_r1_q;
    logic [PW-1:0] wptr_r2_q;
    logic or_q;
    logic [WIDTH-1:0] dout_q;
    logic rd_req;
    logic avail;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wptr_r1_q <= '0;
            wptr_r2_q <= '0;
        end else if (r_edge) begin
            wptr_r1_q <= wptr_q;
            wptr_r2_q <= wptr_r1_q;
        end
    end

    assign rd_req = or_q && !ren_n_s && !oea_n_s && !oeb_n_s;
    assign avail = wptr_r2_q != rptr_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rptr_q <= '0;
            or_q <= 1'b0;
            dout_q <= '0;
        end else if (r_edge) begin
            if ((!or_q || rd_req) && avail) begin
                dout_q <= mem[rptr_q[AW-1:0]];
                rptr_q <= rptr_q + PW'(1);
                or_q <= 1'b1;
            end else if (rd_req) begin
                or_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // Level flags
    logic [PW-1:0] count;
    logic hf_q;
    logic af_q;

    assign count = wptr_q - rptr_q + PW'(or_q);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hf_q <= 1'b0;
            af_q <= 1'b1;
        end else begin
            hf_q <= count >= HALF_LEVEL;
            af_q <= (count <= PW'(ofs_empty_q)) || (count >= DEPTH_WORDS - PW'(ofs_full_q));
        end
    end

    // ==========================================
    // Outputs
    assign input_ready_flag = ir_q;
    assign output_ready_flag = or_q;
    assign half_full_flag = hf_q;
    assign almost_flag = af_q;
    assign data_out = dout_q;
    assign data_out_en = !oea_n_s && !oeb_n_s;

    // ==========================================
    // Register port
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            if (reg_addr == REG_STATUS) begin
                reg_rdata[ST_COUNT_LSB +: PW] <= count;
                reg_rdata[ST_IR_BIT] <= ir_q;
                reg_rdata[ST_OR_BIT] <= or_q;
                reg_rdata[ST_HF_BIT] <= hf_q;
                reg_rdata[ST_AF_BIT] <= af_q;
                reg_rdata[ST_PROG_BIT] <= ofs_q != CFP_OFS_SHUT;
            end else if (reg_addr == REG_OFFSET) begin
                reg_rdata[OF_EMPTY_LSB +: OFS_W] <= ofs_empty_q;
                reg_rdata[OF_FULL_LSB +: OFS_W] <= ofs_full_q;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================
    // Checks
    property p_write_qual;
        @(posedge clk) disable iff (!rst_b)
        (wptr_q != $past(wptr_q)) |-> $past(w_edge && wea_s && !web_s && ir_q);
    endproperty
    a_write_qual: assert property (p_write_qual) else $error("write without qualification");

    property p_full_blocks;
        @(posedge clk) disable iff (!rst_b)
        !ir_q |=> $stable(wptr_q);
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("write while not ready");

    property p_ir_on_edge;
        @(posedge clk) disable iff (!rst_b)
        $rose(ir_q) |-> $past(w_edge) && $past(wrdy_q);
    endproperty
    a_ir_on_edge: assert property (p_ir_on_edge) else $error("input ready rose off edge");

    property p_reset_vals;
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !ir_q && !or_q && !hf_q && af_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad flag values at reset");

    property p_empty_hold;
        @(posedge clk) disable iff (!rst_b)
        !or_q |=> or_q || $stable(dout_q);
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("output changed while empty");

    property p_oe_blocks;
        @(posedge clk) disable iff (!rst_b)
        (oea_n_s || oeb_n_s) && or_q |-> !data_out_en ##1 $stable(rptr_q);
    endproperty
    a_oe_blocks: assert property (p_oe_blocks) else $error("read while outputs disabled");

    property p_half;
        @(posedge clk) disable iff (!rst_b)
        ##1 hf_q == ($past(count) >= HALF_LEVEL);
    endproperty
    a_half: assert property (p_half) else $error("half-full flag wrong");

    property p_almost;
        @(posedge clk) disable iff (!rst_b)
        ##1 af_q == (($past(count) <= PW'($past(ofs_empty_q)))
                     || ($past(count) >= DEPTH_WORDS - PW'($past(ofs_full_q))));
    endproperty
    a_almost: assert property (p_almost) else $error("almost flag wrong");

    property p_or_rise;
        @(posedge clk) disable iff (!rst_b)
        $rose(or_q) |-> $past(r_edge) && (dout_q == mem[$past(rptr_q[AW-1:0])]);
    endproperty
    a_or_rise: assert property (p_or_rise) else $error("output ready rose without word");

    property p_prog_block;
        @(posedge clk) disable iff (!rst_b)
        prog_now |-> !wr_fire;
    endproperty
    a_prog_block: assert property (p_prog_block) else $error("write during programming");

endmodule

// [pkg/cfp_pkg.sv]
package cfp_pkg;

    // ==========================================
    // Geometry
    localparam int DATA_W = 18;
    localparam int ADDR_W = 6;
    localparam int OFS_W = 5;

    // ==========================================
    // Flag levels and defaults
    localparam logic [ADDR_W:0] DEPTH_WORDS = 7'h40;
    localparam logic [ADDR_W:0] HALF_LEVEL = 7'h20;
    localparam logic [OFS_W-1:0] DEFAULT_OFFSET = 5'h08;

    // ==========================================
    // Register map
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h00;
    localparam logic [REG_AW-1:0] REG_OFFSET = 8'h04;

    // Status register fields
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_IR_BIT = 8;
    localparam int ST_OR_BIT = 9;
    localparam int ST_HF_BIT = 10;
    localparam int ST_AF_BIT = 11;
    localparam int ST_PROG_BIT = 12;

    // Offset register fields
    localparam int OF_EMPTY_LSB = 0;
    localparam int OF_FULL_LSB = 8;

    // ==========================================
    // Offset programming states
    typedef enum logic [2:0] {
        CFP_OFS_OPEN = 3'b001,
        CFP_OFS_LOAD = 3'b010,
        CFP_OFS_SHUT = 3'b100
    } cfp_ofs_e;

endpackage

// [test/cfp_ends.sv]
`timescale 1ns/100ps
// ==========================================
// Writer and reader on the pin side
module cfp_ends
    import cfp_pkg::*;
(
    // System
    input wire logic clk,
    // Write pins
    output logic write_clock,
    output logic write_enable_a,
    output logic write_enable_b,
    output logic offset_program_strobe,
    output logic [DATA_W-1:0] data_in,
    // Read pins
    output logic read_clock,
    output logic read_enable_n,
    output logic output_enable_a_n,
    output logic output_enable_b_n,
    // Read status
    input wire logic data_out_en
);
    logic [1:0] ph_q;

    initial begin
        ph_q = 2'h0;
        write_clock = 1'b0;
        read_clock = 1'b0;
        write_enable_a = 1'b0;
        write_enable_b = 1'b1;
        offset_program_strobe = 1'b1;
        data_in = 18'h15555;
        read_enable_n = 1'b1;
        output_enable_a_n = 1'b0;
        output_enable_b_n = 1'b0;
    end

    // free running, read one clk ahead
    always @(posedge clk) begin
        ph_q <= ph_q + 2'h1;
        write_clock <= ph_q[1];
        read_clock <= ph_q[1] ^ ph_q[0];
    end

    task automatic drive(input logic [DATA_W-1:0] w, input logic a, input logic b, input logic p);
        @(posedge clk iff ph_q == 2'h1);
        write_enable_a <= a;
        write_enable_b <= b;
        offset_program_strobe <= p;
        data_in <= w;
        repeat (3) @(posedge clk);
    endtask

    // Released data no longer shows the word
    task automatic idle();
        write_enable_a <= 1'b0;
        write_enable_b <= 1'b1;
        offset_program_strobe <= 1'b1;
        data_in <= ~data_in;
        repeat (4) @(posedge clk);
    endtask

    task automatic put(input logic [DATA_W-1:0] w, input logic a, input logic b);
        drive(w, a, b, 1'b1);
        idle();
    endtask

    task automatic pull(input logic r, input logic a, input logic b, output logic en);
        @(posedge clk iff ph_q == 2'h0);
        read_enable_n <= r;
        output_enable_a_n <= a;
        output_enable_b_n <= b;
        @(posedge clk iff ph_q == 2'h0);
        en = data_out_en;
        read_enable_n <= 1'b1;
        output_enable_a_n <= 1'b0;
        output_enable_b_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// [test/clocked_fifo_64x18_prog_flags_tb.sv]
`timescale 1ns/100ps
module clocked_fifo_64x18_prog_flags_tb;
    import cfp_pkg::*;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic write_clock, write_enable_a, write_enable_b, offset_program_strobe, read_clock;
    logic read_enable_n, output_enable_a_n, output_enable_b_n, data_out_en;
    logic input_ready_flag, output_ready_flag, half_full_flag, almost_flag;
    logic [DATA_W-1:0] data_in, data_out;
    logic [REG_AW-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, v;
    logic en_seen;
    int num_errors = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    cfp_fifo dut_u (.clk, .rst_b, .write_clock, .write_enable_a, .write_enable_b, .offset_program_strobe,
        .data_in, .input_ready_flag, .read_clock, .read_enable_n, .output_enable_a_n, .output_enable_b_n,
        .data_out, .data_out_en, .output_ready_flag, .half_full_flag, .almost_flag, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    cfp_ends ends_u (.clk, .write_clock, .write_enable_a, .write_enable_b, .offset_program_strobe,
        .data_in, .read_clock, .read_enable_n, .output_enable_a_n, .output_enable_b_n, .data_out_en);

    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [REG_AW-1:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask

    // Release while the write clock has been low
    task automatic reset_fifo();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        chk("rst_flags", 32'({input_ready_flag, output_ready_flag, half_full_flag, almost_flag}), 32'h1);
        @(posedge clk iff ends_u.ph_q == 2'h1);
        rst_b <= 1'b1;
        #1;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_flow();
        logic [2:0] cs [3];
        cs = '{3'b100, 3'b010, 3'b001};
        reset_fifo();
        tick(7);
        chk("ir_early", 32'(input_ready_flag), 32'h0);
        tick(3);
        chk("ir_up", 32'(input_ready_flag), 32'h1);
        ends_u.put(18'h2aaaa, 1'b1, 1'b0);
        tick(6);
        chk("or_early", 32'(output_ready_flag), 32'h0);
        tick(6);
        chk("first", 32'({output_ready_flag, data_out}), 32'h6aaaa);
        ends_u.put(18'h11111, 1'b0, 1'b0);
        ends_u.put(18'h22222, 1'b1, 1'b1);
        ends_u.put(18'h3c3c3, 1'b1, 1'b0);
        tick(16);
        foreach (cs[i]) begin
            ends_u.pull(cs[i][2], cs[i][1], cs[i][0], en_seen);
            chk("float", 32'(en_seen), 32'(cs[i][1:0] == 2'b00));
            chk("held", 32'({output_ready_flag, data_out}), 32'h6aaaa);
        end
        ends_u.pull(1'b0, 1'b0, 1'b0, en_seen);
        chk("next", 32'({data_out_en, output_ready_flag, data_out}), 32'hfc3c3);
        repeat (2) begin
            ends_u.pull(1'b0, 1'b0, 1'b0, en_seen);
            chk("empty", 32'({output_ready_flag, data_out}), 32'h3c3c3);
        end
        $display("test flow done");
    endtask

    task automatic t_fill();
        reset_fifo();
        tick(10);
        for (int i = 1; i <= 66; i++) begin
            ends_u.put(18'h20000 | 18'(i), 1'b1, 1'b0);
            chk("flags", 32'({almost_flag, half_full_flag}), 32'({i <= 8 || i >= 56, i >= 32}));
        end
        chk("full", 32'(input_ready_flag), 32'h0);
        for (int k = 1; k <= 64; k++) begin
            chk("drain", 32'(data_out), 32'h20000 | 32'(k));
            ends_u.pull(1'b0, 1'b0, 1'b0, en_seen);
            if (k == 1) begin
                tick(12);
                chk("ir_back", 32'(input_ready_flag), 32'h1);
            end
        end
        $display("test fill done");
    endtask

    task automatic t_prog();
        reset_fifo();
        tick(10);
        rd(REG_OFFSET);
        chk("ofs_dflt", v, 32'h0808);
        ends_u.drive(18'h00003, 1'b1, 1'b0, 1'b0);
        ends_u.drive(18'h00005, 1'b1, 1'b0, 1'b0);
        ends_u.idle();
        rd(REG_OFFSET);
        chk("ofs_prog", v, 32'h0503);
        rd(REG_STATUS);
        chk("no_write", {25'h0, v[6:0]}, 32'h0);
        for (int i = 1; i <= 4; i++) begin
            ends_u.put(18'h00100 + 18'(i), 1'b1, 1'b0);
            chk("almost_p", 32'(almost_flag), 32'(i < 4));
        end
        wr(REG_OFFSET, 32'h0000_0004);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08);
        chk("unmapped", v, 32'h0);
        rd(REG_OFFSET);
        chk("ofs_wr", v, 32'h0004);
        chk("almost_w", 32'(almost_flag), 32'h1);
        $display("test prog done");
    endtask

    // ==========================================
    // Verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        t_flow();
        t_fill();
        t_prog();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule
